// ===== rtl/bsc_defines.svh
/*
 Offsets, field positions and reset values of the bridge status word.
 Assumes inclusion by bare name from rtl/ sources.
*/
`ifndef BSC_DEFINES_SVH
`define BSC_DEFINES_SVH
`define BSC_STATUS_OFFSET 8'h84
`define BSC_FUNC_LSB 0
`define BSC_FUNC_MSB 2
`define BSC_DEV_LSB 3
`define BSC_DEV_MSB 7
`define BSC_BUS_LSB 8
`define BSC_BUS_MSB 15
`define BSC_WIDE_BIT 16
`define BSC_FUNC_RESET 3'h0
`define BSC_DEV_RESET 5'h1f
`define BSC_BUS_RESET 8'hff
`define BSC_CMD_CFG_WRITE 4'hb
`define BSC_CMD_CFG_READ 4'ha
`endif

// ===== rtl/bsc_pkg.sv
/*
 Types shared by the bridge status capture block.
 Assumes bsc_defines.svh is on the include path.
*/
package bsc_pkg;
   typedef struct packed {
      logic [3:0] cmd;
      logic idsel;
      logic [15:0] ad_low;
      logic [7:0] reg_off;
   } bsc_addr_phase_t;

   typedef struct packed {
      logic [7:0] bus;
      logic [4:0] dev;
      logic [2:0] func;
   } bsc_completer_id_t;
endpackage

// ===== rtl/bsc_status.sv
/*
 Bridge status word: function, device and bus numbers, primary 64-bit
 flag, read through the configuration read port; completer ID output.
 Assumes address phase strobes are already in ref_clk domain; the
 straps and the reverse-mode pin are asynchronous and are synchronised.
*/
`timescale 1ns/1ns
`include "bsc_defines.svh"
module bsc_status
   import bsc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic addr_valid,
   input bsc_addr_phase_t addr_phase,
   input wire logic [7:0] primary_bus_num,
   input wire logic wide_device_strap,
   input wire logic wide_request_n,
   input wire logic reverse_mode,
   input wire logic rd_en,
   input wire logic [7:0] rd_addr,
   output logic [31:0] rd_data,
   output logic rd_valid,
   output bsc_completer_id_t completer_id
);
   localparam int PIN_COUNT = 3;

   logic [2:0] func_ff;
   logic [4:0] dev_ff;
   logic wide_cap_ff;
   logic wide_seen_ff;
   logic wide_bit;
   logic rst_d_ff;
   logic [PIN_COUNT-1:0] pin_raw;
   logic [PIN_COUNT-1:0] pin_s;
   logic strap_s;
   logic req_n_s;
   logic rev_s;
   logic cfg_hit;
   logic [4:0] hit_dev;
   logic rd_hit;
   logic [31:0] status_word;
   logic [31:0] rd_data_ff;
   logic rd_valid_ff;
   bsc_completer_id_t completer_id_ff;

   // Pins gathered so one loop builds every synchroniser
   assign pin_raw[0] = wide_device_strap;
   assign pin_raw[1] = wide_request_n;
   assign pin_raw[2] = reverse_mode;

   // Synchronisers run through reset, so pins are settled at release
   generate
      for (genvar g = 0; g < PIN_COUNT; g++)
      begin : g_pin_sync
         bsc_sync2 u_sync
         (
            .ref_clk(ref_clk),
            .din(pin_raw[g]),
            .dout(pin_s[g])
         );
      end
   endgenerate

   assign strap_s = pin_s[0];
   assign req_n_s = pin_s[1];
   assign rev_s = pin_s[2];

   // Only writes aimed at our own function count
   assign cfg_hit = addr_valid
      && (addr_phase.cmd == `BSC_CMD_CFG_WRITE)
      && addr_phase.idsel
      && (addr_phase.ad_low[10:8] == func_ff);

   // Device number carried by the address phase
   assign hit_dev = addr_phase.ad_low[15:11];

   // Function number never written; fixed single-function bridge
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         func_ff <= `BSC_FUNC_RESET;
   end

   // Any register targeted; offset deliberately ignored
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         dev_ff <= `BSC_DEV_RESET;
      else if (cfg_hit)
         dev_ff <= hit_dev;
   end

   // Release marker: high only up to the first edge after reset
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         rst_d_ff <= 1'b1;
      else
         rst_d_ff <= 1'b0;
   end

   // Mode pins latched once, from values synchronised before release
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         wide_cap_ff <= 1'b0;
      else if (rst_d_ff)
         wide_cap_ff <= rev_s && !req_n_s;
   end

   // Strap support is sticky; a late strap still reports 64-bit
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         wide_seen_ff <= 1'b0;
      else if (!rst_d_ff && strap_s)
         wide_seen_ff <= 1'b1;
   end

   assign wide_bit = wide_cap_ff || wide_seen_ff;

   always_comb
   begin
      status_word = 32'h0000_0000;
      status_word[`BSC_FUNC_MSB:`BSC_FUNC_LSB] = func_ff;
      status_word[`BSC_DEV_MSB:`BSC_DEV_LSB] = dev_ff;
      status_word[`BSC_BUS_MSB:`BSC_BUS_LSB] = primary_bus_num;
      status_word[`BSC_WIDE_BIT] = wide_bit;
   end

   assign rd_hit = rd_en && (rd_addr == `BSC_STATUS_OFFSET);

   // Every strobe answered one cycle later, unmapped offsets too
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         rd_valid_ff <= 1'b0;
      else
         rd_valid_ff <= rd_en;
   end

   // Data holds until the next strobe; unmapped offsets read zero
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         rd_data_ff <= 32'h0000_0000;
      else if (rd_hit)
         rd_data_ff <= status_word;
      else if (rd_en)
         rd_data_ff <= 32'h0000_0000;
   end

   assign rd_data = rd_data_ff;
   assign rd_valid = rd_valid_ff;

   // Registered ID; device field follows the same hit as dev_ff
   // Bus field tracks its input in reset too, one cycle behind, so it never holds a reset value
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         completer_id_ff.bus <= primary_bus_num;
         completer_id_ff.dev <= `BSC_DEV_RESET;
         completer_id_ff.func <= `BSC_FUNC_RESET;
      end
      else
      begin
         completer_id_ff.bus <= primary_bus_num;
         completer_id_ff.dev <= cfg_hit ? hit_dev : dev_ff;
         completer_id_ff.func <= func_ff;
      end
   end

   // Also valid for mixed conventional/PCI-X operation
   assign completer_id = completer_id_ff;
endmodule // bsc_status

// ===== rtl/bsc_sync2.sv
/*
 Two-flop synchroniser for one level from a pin.
 Assumes the input is asynchronous to ref_clk.
*/
`timescale 1ns/1ns
module bsc_sync2
(
   input wire logic ref_clk,
   input wire logic din,
   output logic dout
);
   logic meta_ff;
   logic hold_ff;

   // No reset: pin level must already be settled when reset lets go
   always_ff @(posedge ref_clk)
   begin
      meta_ff <= din;
      hold_ff <= meta_ff; // First stage feeds only the second
   end

   assign dout = hold_ff;
endmodule // bsc_sync2

// ===== tb/bsc_checker.sv
/* Status word checker. Bound to bsc_status, sees its ports except wide_request_n and reverse_mode. */
`timescale 1ns/1ns
module bsc_checker
   import bsc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic addr_valid,
   input bsc_addr_phase_t addr_phase,
   input wire logic [7:0] primary_bus_num,
   input wire logic wide_device_strap,
   input wire logic rd_en,
   input wire logic [7:0] rd_addr,
   input wire logic [31:0] rd_data,
   input wire logic rd_valid,
   input bsc_completer_id_t completer_id
);
   wire hit = addr_valid && addr_phase.cmd == 4'hb && addr_phase.idsel &&
      addr_phase.ad_low[10:8] == 3'h0;
   wire rd84 = rd_en && rd_addr == 8'h84;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   sequence cfg_hit; hit; endsequence
   func_zero_a: assert property (completer_id.func == 3'h0)
      else $error("func");
   dev_load_a: assert property (cfg_hit |=>
      completer_id.dev == $past(addr_phase.ad_low[15:11])) else $error("dev");
   dev_hold_a: assert property (!hit |=> $stable(completer_id.dev))
      else $error("hold");
   bus_id_a: assert property (completer_id.bus ==
      $past(primary_bus_num)) else $error("bus");
   rd_pulse_a: assert property (rd_en |=> rd_valid) else $error("valid");
   rd_word_a: assert property (rd84 |=>
      rd_data[15:0] == {$past(primary_bus_num), $past(completer_id.dev),
      $past(completer_id.func)} && rd_data[31:17] == 15'h0)
      else $error("word");
   rd_zero_a: assert property (rd_en && !rd84 |=> rd_data == 32'h0)
      else $error("zero");
   wide_set_a: assert property (wide_device_strap [*5] ##1 rd84 |=>
      rd_data[16]) else $error("wide");
endmodule // bsc_checker

// ===== tb/bsc_host_model.sv
/* Configuration host model. Driven by testbench task calls. */
`timescale 1ns/1ns
module bsc_host_model
   import bsc_pkg::*;
(
   input wire logic ref_clk,
   output logic addr_valid,
   output bsc_addr_phase_t addr_phase
);
   initial addr_valid = 1'b0;
   initial addr_phase = '0;
   task cfg(input logic [3:0] c, input logic s, input logic [15:0] a);
      @(posedge ref_clk);
      addr_valid <= 1'b1;
      addr_phase <= '{c, s, a, 8'h84};
      @(posedge ref_clk);
      addr_valid <= 1'b0;
      // Released bus: never leave the old address showing
      addr_phase <= ~addr_phase;
   endtask
endmodule // bsc_host_model

// ===== tb/testbench.sv
/* Testbench of bsc_status. Host model drives address phases. */
`timescale 1ns/1ns
module testbench;
   import bsc_pkg::*;
   logic ref_clk = 1'b0, rst = 1'b1, strap = 1'b0, wreq_n = 1'b0, rev = 1'b1;
   logic rd_en = 1'b0, rd_valid, av, s;
   logic [7:0] rd_addr = 8'h84, bus = 8'h00;
   logic [3:0] c;
   logic [15:0] a;
   logic [31:0] rd_data;
   bsc_addr_phase_t ap;
   bsc_completer_id_t cid;
   integer seed = 81213, err_total = 0, cmp_count = 0, cyc = 0, dev_m, wm, i;
   always #2 ref_clk = ~ref_clk;
   bsc_host_model i_host (.ref_clk, .addr_valid(av), .addr_phase(ap));
   bsc_status i_dut (.ref_clk, .rst, .addr_valid(av), .addr_phase(ap),
      .primary_bus_num(bus), .wide_device_strap(strap),
      .wide_request_n(wreq_n), .reverse_mode(rev), .rd_en, .rd_addr,
      .rd_data, .rd_valid, .completer_id(cid));
   task chk(input logic [31:0] g, e);
      cmp_count++;
      if (g !== e)
      begin
         err_total++;
         $display("wrong value t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task rd(input logic [7:0] ad);
      @(posedge ref_clk);
      rd_en <= 1'b1;
      rd_addr <= ad;
      @(posedge ref_clk);
      rd_en <= 1'b0;
      #1;
      chk(rd_data, ad != 8'h84 ? 32'h0 :
         {15'h0, wm[16], bus, dev_m[4:0], 3'h0});
      chk({31'h0, rd_valid}, 32'h1);
      chk({16'h0, cid}, {16'h0, bus, dev_m[4:0], 3'h0});
   endtask
   task rst_run(input logic r, w);
      @(posedge ref_clk);
      rst <= 1'b1;
      {rev, wreq_n, strap} <= {r, w, 1'b0};
      repeat (7) @(posedge ref_clk);
      rst <= 1'b0;
      dev_m = 31;
      wm = {r & ~w, 16'h0};
      repeat (3) @(posedge ref_clk);
   endtask
   task finish_test;
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   always @(posedge ref_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 2000)
      begin
         err_total++;
         finish_test;
      end
   end
   initial
   begin
      for (i = 0; i < 3; i++)
      begin
         rst_run(i != 1, i == 2);
         rd(8'h84);
         $display("test %0d done", i);
      end
      for (i = 0; i < 24; i++)
      begin
         c = i[0] ? 4'hb : 4'($random(seed));
         s = 1'($random(seed)) | i[1];
         a = 16'($random(seed));
         // Force a function match now and then so writes really land
         if (i[2]) a[10:8] = 3'h0;
         i_host.cfg(c, s, a);
         bus <= 8'($random(seed));
         if (c == 4'hb && s && a[10:8] == 3'h0) dev_m = a[15:11];
         rd(i[3] ? 8'h84 : 8'h80);
      end
      $display("test 3 done");
      @(posedge ref_clk);
      strap <= 1'b1;
      wm = 32'h10000;
      repeat (5) @(posedge ref_clk);
      rd(8'h84);
      $display("test 4 done");
      finish_test;
   end
endmodule // testbench
bind bsc_status bsc_checker i_chk (.ref_clk, .rst, .addr_valid, .addr_phase,
   .primary_bus_num, .wide_device_strap, .rd_en, .rd_addr, .rd_data,
   .rd_valid, .completer_id);
